// [lcai_pkg.sv]
/*
 * Shared constants and types for the line channel alarm interrupt block:
 * register map, field positions, reset values, timing counts, state types.
 * Assumes one 100 MHz clock and a 32-bit AHB-Lite register bus.
 */
package lcai_pkg;

	// ------------------------------------------------------------------
	// Clock and line timing
	// ------------------------------------------------------------------
	localparam int unsigned LCAI_CLK_PERIOD_PS = 10000;
	localparam int unsigned LCAI_BIT_PERIOD_PS = 488281; // One 2.048 Mbit/s bit
	// Shortest time, so the cycle count rounds down
	localparam logic [5:0]  LCAI_BIT_CYCLES    = 6'(LCAI_BIT_PERIOD_PS / LCAI_CLK_PERIOD_PS);
	localparam logic [5:0]  LCAI_BIT_LAST      = LCAI_BIT_CYCLES - 6'h1;
	localparam logic [7:0]  LCAI_QUIET_BITS    = 8'h80; // Pulse-free bits before alarm
	localparam logic [7:0]  LCAI_QUIET_LAST    = LCAI_QUIET_BITS - 8'h01;

	// ------------------------------------------------------------------
	// Register map: printed indices, byte address is four times each
	// ------------------------------------------------------------------
	localparam logic [7:0]  LCAI_IDX_ENABLE    = 8'h04;
	localparam logic [7:0]  LCAI_IDX_STATUS    = 8'h05;
	localparam logic [7:0]  LCAI_IDX_EVENT     = 8'h06;
	localparam logic [7:0]  LCAI_IDX_CLEAR     = 8'h07;
	localparam logic [7:0]  LCAI_IDX_CONFIG    = 8'h08;
	localparam logic [7:0]  LCAI_ADDR_ENABLE   = 8'(LCAI_IDX_ENABLE * 4);
	localparam logic [7:0]  LCAI_ADDR_STATUS   = 8'(LCAI_IDX_STATUS * 4);
	localparam logic [7:0]  LCAI_ADDR_EVENT    = 8'(LCAI_IDX_EVENT * 4);
	localparam logic [7:0]  LCAI_ADDR_CLEAR    = 8'(LCAI_IDX_CLEAR * 4);
	localparam logic [7:0]  LCAI_ADDR_CONFIG   = 8'(LCAI_IDX_CONFIG * 4);

	// ------------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------------
	localparam int unsigned LCAI_BIT_QRSS      = 0;
	localparam int unsigned LCAI_BIT_LOS       = 1;
	localparam int unsigned LCAI_BIT_DMO       = 6;
	localparam int unsigned LCAI_BIT_RAIL      = 0;
	localparam int unsigned LCAI_TRANS_ACTIVE  = 1; // htrans[1]: NONSEQ or SEQ
	localparam logic [7:0]  LCAI_ALARM_MASK    = 8'h43;
	localparam logic [7:0]  LCAI_RST_BYTE      = 8'h00;
	localparam logic [31:0] LCAI_RD_ZERO       = 32'h0000_0000;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		LCAI_BUS_IDLE   = 2'h0,
		LCAI_BUS_RDWAIT = 2'h1,
		LCAI_BUS_RDDONE = 2'h3,
		LCAI_BUS_WRITE  = 2'h2
	} lcai_bus_st_t;

	typedef struct packed {
		logic        sel;
		logic [1:0]  trans;
		logic        write;
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        ready;
	} lcai_ahb_req_t;

	typedef struct packed {
		lcai_bus_st_t bus;
		logic [7:0]   addr;
		logic [7:0]   enable;
		logic [7:0]   events;
		logic [7:0]   alarm_prev;
		logic         single_rail;
		logic [31:0]  rdata;
		logic         irq;
	} lcai_state_t;

	typedef struct packed {
		logic [1:0] sync1;
		logic [1:0] sync2;
		logic [5:0] div;
		logic [7:0] quiet;
		logic       alarm;
	} lcai_dmo_state_t;

endpackage : lcai_pkg

// [lcai_dmo_mon.sv]
/*
 * Transmit driver monitor: watches the transmit line pair for bipolar
 * pulses and declares an alarm after a run of pulse-free bit periods.
 * Assumes the line pins are asynchronous to mclk.
 */
`timescale 1ns/1ps
module lcai_dmo_mon
	import lcai_pkg::*;
(
	// Clock and reset
	input  wire logic mclk,
	input  wire logic sys_rst,
	// Transmit line pair
	input  wire logic tx_line_positive,
	input  wire logic tx_line_negative,
	// Alarm state
	output logic      driver_monitor_alarm
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	lcai_dmo_state_t st_q;
	lcai_dmo_state_t st_d;
	logic            pulse;
	logic            tick;

	// Either rail high means a mark went out
	assign pulse = |st_q.sync2;
	assign tick  = (st_q.div == LCAI_BIT_LAST);

	// Sync, bit-period divider and quiet-bit counter
	always_comb begin
		st_d       = st_q;
		st_d.sync1 = {tx_line_positive, tx_line_negative};
		st_d.sync2 = st_q.sync1;
		st_d.div   = tick ? 6'h0 : st_q.div + 6'h1;
		if (pulse) begin
			// Activity ends the alarm at once, no hold-off
			st_d.quiet = 8'h00; // R6
			st_d.alarm = 1'b0; // R6
		end else if (tick) begin
			if (st_q.quiet == LCAI_QUIET_LAST) begin
				st_d.alarm = 1'b1; // R5
			end else begin
				st_d.quiet = st_q.quiet + 8'h01; // R5
			end
		end
	end

	// State register
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign driver_monitor_alarm = st_q.alarm;

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	property p_dmo_declare;
		@(posedge mclk) disable iff (sys_rst)
		(tick && !pulse && st_q.quiet == LCAI_QUIET_LAST) |=> st_q.alarm;
	endproperty
	a_dmo_declare: assert property (p_dmo_declare) else $error("alarm not declared"); // R5

	property p_dmo_early;
		@(posedge mclk) disable iff (sys_rst)
		$rose(st_q.alarm) |-> $past(st_q.quiet) == LCAI_QUIET_LAST && $past(tick);
	endproperty
	a_dmo_early: assert property (p_dmo_early) else $error("alarm declared early"); // R5

	property p_dmo_clear;
		@(posedge mclk) disable iff (sys_rst)
		pulse |=> !st_q.alarm && st_q.quiet == 8'h00;
	endproperty
	a_dmo_clear: assert property (p_dmo_clear) else $error("alarm not cleared"); // R6

	c_dmo_rise: cover property (@(posedge mclk) disable iff (sys_rst) $rose(st_q.alarm));

endmodule : lcai_dmo_mon

// [lcai_top.sv]
/*
 * Line channel alarm interrupt block: AHB-Lite register slave, alarm
 * change detection, sticky events, interrupt output, driver monitor.
 * Assumes receive loss and pattern-detect levels come from mclk logic;
 * transmit line pins are asynchronous and synchronised in the monitor.
 */
// The implementer's own choices: the address map and register access over AHB-Lite.
`timescale 1ns/1ps

// Behaviour
// R1: Signal-loss change enable set: interrupt on both declare and clear of loss.
// R2: Pattern-detect change enable set: interrupt on both start and end of detection.
// R3: Enable, status and event registers act only while single-rail is configured.
// R4: Software also configures the framer for single-rail when choosing single-rail.
// R5: Declare driver alarm after 128 consecutive pulse-free bit periods.
// R6: Clear driver alarm at once when any pulse reappears.
// R7: Driver alarm reads in status bit 6, read-only.
// R8: Driver interrupt enable set: every alarm status transition raises interrupt.
// R9: Driver interrupt enable is read-write bit 6, resetting to zero.
// R10: Detect changes against previous clock; request only when enable set.
module lcai_top
	import lcai_pkg::*;
(
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Receive alarm levels from the receive section
	input  wire logic        rx_signal_loss,
	input  wire logic        rx_qrss_detect,
	// Transmit line pair
	input  wire logic        tx_line_positive,
	input  wire logic        tx_line_negative,
	// Interrupt
	output logic             line_alarm_irq
);

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	lcai_state_t   st_q;
	lcai_state_t   st_d;
	lcai_ahb_req_t req;
	logic          driver_monitor_alarm;
	logic [7:0]    alarm_now;
	logic [7:0]    alarm_change;
	logic [7:0]    event_set;
	logic [7:0]    event_clr;
	logic [7:0]    wdata8;
	logic          accept;
	logic          data_write;
	logic [1:0]    size_unused;

	// ------------------------------------------------------------------
	// Driver monitor
	// ------------------------------------------------------------------
	lcai_dmo_mon u_dmo (
		.mclk                 (mclk),
		.sys_rst              (sys_rst),
		.tx_line_positive     (tx_line_positive),
		.tx_line_negative     (tx_line_negative),
		.driver_monitor_alarm (driver_monitor_alarm)
	);

	// ------------------------------------------------------------------
	// Bus request bundle
	// ------------------------------------------------------------------
	// Only the low address byte decodes; hsel covers the rest
	always_comb begin
		req.sel   = hsel;
		req.trans = htrans;
		req.write = hwrite;
		req.addr  = haddr[7:0];
		req.wdata = hwdata;
		req.ready = hready;
	end

	// Only word transfers are issued, so size is not decoded
	assign size_unused = hsize[1:0];
	assign wdata8      = req.wdata[7:0];

	// New address phase taken when the bus is ready
	assign accept     = req.sel && req.trans[LCAI_TRANS_ACTIVE] && req.ready;
	// Write data phase completes in its first cycle
	assign data_write = (st_q.bus == LCAI_BUS_WRITE);

	// ------------------------------------------------------------------
	// Alarm change detection
	// ------------------------------------------------------------------
	// Current alarm levels gathered in status layout
	always_comb begin
		alarm_now                = LCAI_RST_BYTE;
		alarm_now[LCAI_BIT_QRSS] = rx_qrss_detect;
		alarm_now[LCAI_BIT_LOS]  = rx_signal_loss;
		alarm_now[LCAI_BIT_DMO]  = driver_monitor_alarm;
	end

	// Both edges count, so XOR with last clock's copy
	assign alarm_change = (alarm_now ^ st_q.alarm_prev) & LCAI_ALARM_MASK; // R10

	// Enabled changes only, and only in single-rail operation
	assign event_set = alarm_change & st_q.enable & {8{st_q.single_rail}}; // R1 R2 R8 R3

	// Write-one-to-clear strobe from the clear register
	always_comb begin
		event_clr = LCAI_RST_BYTE;
		if (data_write && st_q.addr == LCAI_ADDR_CLEAR) begin
			event_clr = wdata8 & LCAI_ALARM_MASK;
		end
	end

	// ------------------------------------------------------------------
	// Register read mux
	// ------------------------------------------------------------------
	function automatic logic [31:0] lcai_read(input lcai_state_t s, input logic [7:0] now);
		logic [31:0] v;
		v = LCAI_RD_ZERO;
		case (s.addr)
			LCAI_ADDR_ENABLE: begin
				v[7:0] = s.enable;
			end
			LCAI_ADDR_STATUS: begin
				// Levels are meaningless outside single-rail, so hide them
				if (s.single_rail) begin
					v[7:0] = now; // R7 R3
				end
			end
			LCAI_ADDR_EVENT: begin
				v[7:0] = s.events;
			end
			LCAI_ADDR_CONFIG: begin
				v[LCAI_BIT_RAIL] = s.single_rail;
			end
			default: begin
				// Clear register and unmapped space read zero
				v = LCAI_RD_ZERO;
			end
		endcase
		return v;
	endfunction : lcai_read

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	// One combinational copy of the whole state
	always_comb begin
		st_d            = st_q;
		st_d.alarm_prev = alarm_now; // R10

		// Register writes land at the end of the data phase
		if (data_write) begin
			case (st_q.addr)
				LCAI_ADDR_ENABLE: begin
					// Writes ignored unless single-rail is on
					if (st_q.single_rail) begin
						st_d.enable = wdata8 & LCAI_ALARM_MASK; // R9 R3
					end
				end
				LCAI_ADDR_CONFIG: begin
					st_d.single_rail = wdata8[LCAI_BIT_RAIL];
				end
				default: begin
					// Status and event are read-only; unmapped ignored
					st_d.single_rail = st_q.single_rail; // R7
				end
			endcase
		end

		// Set wins over a clear in the same cycle, so no event is lost
		st_d.events = (st_q.events & ~event_clr) | event_set; // R10

		// Level interrupt from enabled sticky bits
		st_d.irq = |(st_d.events & st_d.enable); // R10

		// Bus phase tracking; reads take one wait state for a flopped hrdata
		case (st_q.bus)
			LCAI_BUS_RDWAIT: begin
				st_d.rdata = lcai_read(st_q, alarm_now);
				st_d.bus   = LCAI_BUS_RDDONE;
			end
			LCAI_BUS_IDLE, LCAI_BUS_WRITE, LCAI_BUS_RDDONE: begin
				if (accept) begin
					st_d.addr = req.addr;
					st_d.bus  = req.write ? LCAI_BUS_WRITE : LCAI_BUS_RDWAIT;
				end else begin
					st_d.bus = LCAI_BUS_IDLE;
				end
			end
			default: begin
				st_d.bus = LCAI_BUS_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	// Ready drops only while the read value is being fetched
	assign hreadyout      = (st_q.bus != LCAI_BUS_RDWAIT);
	assign hresp          = 1'b0;
	assign hrdata         = st_q.rdata;
	assign line_alarm_irq = st_q.irq;

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb_main @(posedge mclk);
	endclocking
	default disable iff (sys_rst);

	property p_los_change;
		st_q.single_rail && st_q.enable[LCAI_BIT_LOS] &&
		(rx_signal_loss != st_q.alarm_prev[LCAI_BIT_LOS]) |=> st_q.events[LCAI_BIT_LOS];
	endproperty
	a_los_change: assert property (p_los_change) else $error("loss change missed"); // R1

	property p_los_masked;
		!st_q.enable[LCAI_BIT_LOS] && !st_q.events[LCAI_BIT_LOS] |=> !st_q.events[LCAI_BIT_LOS];
	endproperty
	a_los_masked: assert property (p_los_masked) else $error("masked loss event"); // R1

	property p_qrss_change;
		st_q.single_rail && st_q.enable[LCAI_BIT_QRSS] &&
		$changed(rx_qrss_detect) |=> st_q.events[LCAI_BIT_QRSS];
	endproperty
	a_qrss_change: assert property (p_qrss_change) else $error("pattern change missed"); // R2

	property p_rail_gate;
		!st_q.single_rail && st_q.events == LCAI_RST_BYTE |=> st_q.events == LCAI_RST_BYTE;
	endproperty
	a_rail_gate: assert property (p_rail_gate) else $error("event outside single rail"); // R3

	property p_rail_enable;
		!st_q.single_rail |=> $stable(st_q.enable);
	endproperty
	a_rail_enable: assert property (p_rail_enable) else $error("enable written outside single rail"); // R3

	property p_status_read;
		st_q.bus == LCAI_BUS_RDWAIT && st_q.addr == LCAI_ADDR_STATUS && st_q.single_rail
		|-> !hreadyout ##1 (hreadyout && hrdata[LCAI_BIT_DMO] == $past(driver_monitor_alarm));
	endproperty
	a_status_read: assert property (p_status_read) else $error("status bit 6 wrong"); // R7

	property p_dmo_change;
		st_q.single_rail && st_q.enable[LCAI_BIT_DMO] && $changed(driver_monitor_alarm)
		|=> st_q.events[LCAI_BIT_DMO] ##1 line_alarm_irq || !st_q.enable[LCAI_BIT_DMO];
	endproperty
	a_dmo_change: assert property (p_dmo_change) else $error("driver alarm change missed"); // R8

	property p_enable_write;
		data_write && st_q.addr == LCAI_ADDR_ENABLE && st_q.single_rail
		|=> st_q.enable == ($past(wdata8) & LCAI_ALARM_MASK);
	endproperty
	a_enable_write: assert property (p_enable_write) else $error("enable write lost"); // R9

	property p_event_cause;
		$rose(st_q.events[LCAI_BIT_DMO]) |-> $past(st_q.enable[LCAI_BIT_DMO]) && $past(st_q.single_rail);
	endproperty
	a_event_cause: assert property (p_event_cause) else $error("event without enable"); // R10

	property p_irq_level;
		line_alarm_irq |-> (st_q.events & st_q.enable) != LCAI_RST_BYTE;
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("interrupt without cause"); // R10

	// Masked pattern changes must never stick
	property p_qrss_masked;
		!st_q.enable[LCAI_BIT_QRSS] && !st_q.events[LCAI_BIT_QRSS] |=> !st_q.events[LCAI_BIT_QRSS];
	endproperty
	a_qrss_masked: assert property (p_qrss_masked) else $error("masked pattern event"); // R2

	// Masked driver alarm changes must never stick
	property p_dmo_masked;
		!st_q.enable[LCAI_BIT_DMO] && !st_q.events[LCAI_BIT_DMO] |=> !st_q.events[LCAI_BIT_DMO];
	endproperty
	a_dmo_masked: assert property (p_dmo_masked) else $error("masked driver alarm event"); // R8

	// A change landing with a clear of the same bit is kept
	property p_set_wins;
		(event_set & event_clr) != LCAI_RST_BYTE
		|=> (st_q.events & $past(event_set)) == $past(event_set);
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("event lost to clear"); // R10

	// A clear with no new change empties the written bits
	property p_clear_event;
		data_write && st_q.addr == LCAI_ADDR_CLEAR && event_set == LCAI_RST_BYTE
		|=> (st_q.events & $past(wdata8)) == LCAI_RST_BYTE;
	endproperty
	a_clear_event: assert property (p_clear_event) else $error("event not cleared"); // R10

	// Only the three implemented enable bits can ever hold a one
	property p_enable_bits;
		(st_q.enable & ~LCAI_ALARM_MASK) == LCAI_RST_BYTE;
	endproperty
	a_enable_bits: assert property (p_enable_bits) else $error("reserved enable bit set"); // R9

	// Status writes must not disturb the enable or config register
	property p_status_ro;
		data_write && st_q.addr == LCAI_ADDR_STATUS
		|=> $stable(st_q.enable) && $stable(st_q.single_rail);
	endproperty
	a_status_ro: assert property (p_status_ro) else $error("status write had effect"); // R7

	// Single-rail choice follows the config write
	property p_config_write;
		data_write && st_q.addr == LCAI_ADDR_CONFIG
		|=> st_q.single_rail == $past(wdata8[LCAI_BIT_RAIL]);
	endproperty
	a_config_write: assert property (p_config_write) else $error("config write lost"); // R3

	// Clearing every enable drops the interrupt on the next edge
	property p_irq_enable_drop;
		data_write && st_q.addr == LCAI_ADDR_ENABLE && st_q.single_rail &&
		(wdata8 & LCAI_ALARM_MASK) == LCAI_RST_BYTE |=> !line_alarm_irq;
	endproperty
	a_irq_enable_drop: assert property (p_irq_enable_drop) else $error("interrupt kept after disable"); // R10

	// Read data only moves when a read is fetched
	property p_hrdata_hold;
		st_q.bus != LCAI_BUS_RDWAIT |=> $stable(hrdata);
	endproperty
	a_hrdata_hold: assert property (p_hrdata_hold) else $error("read data moved"); // R7

	c_los_event:  cover property ($rose(st_q.events[LCAI_BIT_LOS]));
	c_dmo_irq:    cover property ($rose(st_q.events[LCAI_BIT_DMO]) ##[1:4] line_alarm_irq);
	c_read_done:  cover property (st_q.bus == LCAI_BUS_RDWAIT ##1 st_q.bus == LCAI_BUS_RDDONE);
	c_set_clear:  cover property ((event_set & event_clr) != LCAI_RST_BYTE);

endmodule : lcai_top

// [lcai_line_src.sv]
/*
 * Far-side model of the transmit line pair: alternate mark inversion
 * pulses, one per bit period, or a silent line on command.
 * Assumes the bench drives active from mclk edges; the pins reach the
 * design as asynchronous levels.
 */
`timescale 1ns/1ps
module lcai_line_src #(
	parameter int BIT_CYCLES = 48
) (
	// Clock and reset
	input  wire logic mclk,
	input  wire logic sys_rst,
	// Bench control
	input  wire logic active,
	// Transmit line pair
	output logic      tx_line_positive,
	output logic      tx_line_negative
);
	int   phase;
	logic polarity;

	// ------------------------------------------------------------------
	// Bit timing
	// ------------------------------------------------------------------
	// Phase restarts while silent so a pulse appears at once on resume
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst || !active) begin
			phase <= 0;
		end else if (phase == BIT_CYCLES - 1) begin
			phase    <= 0;
			polarity <= ~polarity;
		end else begin
			phase <= phase + 1;
		end
	end

	initial polarity = 1'b0;

	// Half-bit marks; both legs low is a space, the driven idle level
	assign tx_line_positive = active & (phase < BIT_CYCLES / 2) & polarity;
	assign tx_line_negative = active & (phase < BIT_CYCLES / 2) & ~polarity;
endmodule : lcai_line_src

// [tb_line_channel_alarm_interrupts.sv]
/*
 * Self-checking bench for the line channel alarm interrupt block:
 * AHB-Lite master tasks, receive alarm levels, transmit line model.
 * Assumes a single slave whose hreadyout is the bus hready.
 */
`timescale 1ns/1ps
module tb_line_channel_alarm_interrupts;
	import lcai_pkg::*;

	logic        mclk, sys_rst, hsel, hwrite, line_active;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans, rx_lv;
	logic [2:0]  hsize;
	logic        hreadyout, hresp, line_alarm_irq, txp, txn;
	int          bad_count, n_compared, cyc;

	lcai_top dut (.mclk(mclk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .rx_signal_loss(rx_lv[1]), .rx_qrss_detect(rx_lv[0]),
		.tx_line_positive(txp), .tx_line_negative(txn), .line_alarm_irq(line_alarm_irq));

	lcai_line_src line (.mclk(mclk), .sys_rst(sys_rst), .active(line_active),
		.tx_line_positive(txp), .tx_line_negative(txn));

	// ------------------------------------------------------------------
	// Reporting
	// ------------------------------------------------------------------
	task automatic give_verdict();
		$display("compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : give_verdict

	task automatic chk_reg(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask : chk_reg

	task automatic chk_irq(input logic exp);
		n_compared++;
		if (line_alarm_irq !== exp) begin
			bad_count++;
			$display("FAIL line_alarm_irq expected %b seen %b", exp, line_alarm_irq);
		end
	endtask : chk_irq

	// ------------------------------------------------------------------
	// Bus master
	// ------------------------------------------------------------------
	// Starts on an edge, holds each phase until hready is sampled high
	task automatic bus(input logic wr, input logic [7:0] addr, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge mclk);
		hsel   <= 1'b1;
		haddr  <= {24'h00_0000, addr};
		hwrite <= wr;
		hsize  <= 3'b010;
		htrans <= 2'b10;
		@(posedge mclk);
		while (hreadyout !== 1'b1) @(posedge mclk);
		htrans <= 2'b00;
		hwdata <= wd;
		@(posedge mclk);
		while (hreadyout !== 1'b1) @(posedge mclk);
		rd = hrdata;
		chk_reg("hresp", 32'h0000_0000, {31'h0000_0000, hresp});
	endtask : bus

	task automatic wr(input logic [7:0] addr, input logic [31:0] d);
		logic [31:0] unused;
		bus(1'b1, addr, d, unused);
	endtask : wr

	task automatic rd_chk(input string what, input logic [7:0] addr, input logic [31:0] exp);
		logic [31:0] got;
		bus(1'b0, addr, 32'h0000_0000, got);
		chk_reg(what, exp, got);
	endtask : rd_chk

	// Level change launched on an edge, looked at after the event edge
	task automatic set_lv(input int b, input logic v);
		@(posedge mclk);
		rx_lv[b] <= v;
		repeat (2) @(posedge mclk);
		#1;
	endtask : set_lv

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic t_reset();
		chk_irq(1'b0);
		rd_chk("enable", LCAI_ADDR_ENABLE, 32'h0000_0000);
		rd_chk("status", LCAI_ADDR_STATUS, 32'h0000_0000);
		rd_chk("event", LCAI_ADDR_EVENT, 32'h0000_0000);
		$display("test reset done");
	endtask : t_reset

	// Before single-rail is chosen nothing should stick or interrupt
	task automatic t_rail_off();
		wr(LCAI_ADDR_ENABLE, 32'h0000_00FF);
		rd_chk("enable", LCAI_ADDR_ENABLE, 32'h0000_0000);
		set_lv(1, 1'b1);
		set_lv(0, 1'b1);
		chk_irq(1'b0);
		rd_chk("status", LCAI_ADDR_STATUS, 32'h0000_0000);
		rd_chk("event", LCAI_ADDR_EVENT, 32'h0000_0000);
		set_lv(1, 1'b0);
		set_lv(0, 1'b0);
		$display("test rail_off done");
	endtask : t_rail_off

	task automatic t_regs();
		wr(LCAI_ADDR_CONFIG, 32'h0000_0001);
		wr(LCAI_ADDR_ENABLE, 32'hFFFF_FFFF);
		rd_chk("enable", LCAI_ADDR_ENABLE, 32'h0000_0043);
		rd_chk("config", LCAI_ADDR_CONFIG, 32'h0000_0001);
		wr(LCAI_ADDR_STATUS, 32'hFFFF_FFFF);
		rd_chk("status", LCAI_ADDR_STATUS, 32'h0000_0000);
		rd_chk("unmapped", 8'h3C, 32'h0000_0000);
		wr(LCAI_ADDR_ENABLE, 32'h0000_0000);
		$display("test regs done");
	endtask : t_regs

	// Both edges of one receive level, then masked
	task automatic t_change(input int b);
		logic [31:0] m;
		m = 32'h0000_0001 << b;
		wr(LCAI_ADDR_ENABLE, m);
		set_lv(b, 1'b1);
		chk_irq(1'b1);
		rd_chk("event", LCAI_ADDR_EVENT, m);
		rd_chk("status", LCAI_ADDR_STATUS, m);
		wr(LCAI_ADDR_CLEAR, m);
		rd_chk("event", LCAI_ADDR_EVENT, 32'h0000_0000);
		chk_irq(1'b0);
		set_lv(b, 1'b0);
		chk_irq(1'b1);
		wr(LCAI_ADDR_ENABLE, 32'h0000_0000);
		#1;
		chk_irq(1'b0);
		wr(LCAI_ADDR_CLEAR, m);
		set_lv(b, 1'b1);
		set_lv(b, 1'b0);
		chk_irq(1'b0);
		rd_chk("event", LCAI_ADDR_EVENT, 32'h0000_0000);
		$display("test change bit %0d done", b);
	endtask : t_change

	// Silent line raises the alarm after the quiet run; a pulse drops it
	task automatic t_dmo();
		logic [31:0] got;
		int          n;
		wr(LCAI_ADDR_ENABLE, 32'h0000_0040);
		@(posedge mclk);
		line_active <= 1'b0;
		repeat (126 * 48) @(posedge mclk);
		rd_chk("status early", LCAI_ADDR_STATUS, 32'h0000_0000);
		n = 0;
		got = 32'h0000_0000;
		while (got[6] !== 1'b1 && n < 200) begin
			bus(1'b0, LCAI_ADDR_STATUS, 32'h0000_0000, got);
			n++;
		end
		chk_reg("status late", 32'h0000_0040, got);
		rd_chk("event", LCAI_ADDR_EVENT, 32'h0000_0040);
		chk_irq(1'b1);
		wr(LCAI_ADDR_CLEAR, 32'h0000_0040);
		#1;
		chk_irq(1'b0);
		@(posedge mclk);
		line_active <= 1'b1;
		n = 0;
		while (line_alarm_irq !== 1'b1 && n < 20) begin
			@(posedge mclk);
			n++;
		end
		chk_reg("clear delay", 32'h0000_0001, {31'h0000_0000, n <= 8});
		rd_chk("status", LCAI_ADDR_STATUS, 32'h0000_0000);
		rd_chk("event", LCAI_ADDR_EVENT, 32'h0000_0040);
		wr(LCAI_ADDR_CLEAR, 32'h0000_0040);
		$display("test dmo done");
	endtask : t_dmo

	// ------------------------------------------------------------------
	// Clock, timeout and main sequence
	// ------------------------------------------------------------------
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// Longest test is the quiet run, about 6.1k cycles
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 30000) begin
			bad_count++;
			give_verdict();
		end
	end

	initial begin
		sys_rst = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0000_0000;
		rx_lv = 2'b00;
		line_active = 1'b1;
		bad_count = 0;
		n_compared = 0;
		cyc = 0;
		repeat (6) @(posedge mclk);
		sys_rst <= 1'b0;
		t_reset();
		t_rail_off();
		t_regs();
		t_change(LCAI_BIT_LOS);
		t_change(LCAI_BIT_QRSS);
		t_dmo();
		give_verdict();
	end
endmodule : tb_line_channel_alarm_interrupts
